// File: pkg/tdl_pkg.sv
`default_nettype none
package tdl_pkg;
  // Clock rate and the once-per-second sampling period.
  localparam int CLK_HZ          = 10_000_000;
  localparam int SAMPLE_PERIOD_S = 1;
  localparam int SEC_CYCLES      = CLK_HZ * SAMPLE_PERIOD_S;
  localparam int CNT_W           = 28;

  // Register offsets on the internal register port.
  localparam logic [7:0] ADDR_FLAGS = 8'h0F;
  localparam logic [7:0] ADDR_CH1   = 8'h14;
  localparam logic [7:0] ADDR_CH2   = 8'h15;

  // Flag bit positions in the event flag register; other bits read zero.
  localparam int FLAG_ONE_BIT = 0;
  localparam int FLAG_TWO_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // External wipe pulse lengths in seconds, selected by the two width bits.
  localparam logic [4:0] WIPE_S_00 = 5'h01;
  localparam logic [4:0] WIPE_S_01 = 5'h04;
  localparam logic [4:0] WIPE_S_10 = 5'h08;
  localparam logic [4:0] WIPE_S_11 = 5'h10;

  // Channel configuration byte, bit 7 first.
  typedef struct packed {
    logic arm;
    logic irq_en;
    logic switch_kind;
    logic trigger_level;
    logic sample_select;
    logic pull_strength;
    logic ram_wipe;
    logic ext_ram_wipe;
  } tdl_cfg_t;

  // System status levels seen by the tamper logic.
  typedef struct packed {
    logic battery_backup;
    logic osc_stopped;
    logic alarm_in_backup_enable;
  } tdl_sys_t;

  // Seconds of external wipe for a width code.
  function automatic logic [4:0] tdl_wipe_secs(input logic [1:0] width);
    logic [4:0] secs;
    secs = WIPE_S_00;
    if (width == 2'h1) begin
      secs = WIPE_S_01;
    end else if (width == 2'h2) begin
      secs = WIPE_S_10;
    end else if (width == 2'h3) begin
      secs = WIPE_S_11;
    end
    return secs;
  endfunction
endpackage
`default_nettype wire

// File: logic/tdl_top.sv
// Summary of operation
// - Two independent channels; each flag sets only while its arm bit is set.
// - Each channel detects a closing or an opening switch per its config bits.
// - Arm bit one activates detection; zero disables it.
// - Flag is read-only, set on tamper while armed, cleared only by disarming.
// - Interrupt enable drives the interrupt output on that channel's tamper.
// - In battery backup, interrupt drives only with alarm-in-backup enabled.
// - Switch kind one means normally open, zero normally closed.
// - Trigger level one triggers on input high, zero on input low.
// - Normally closed: sample select picks once-per-second or continuous checking.
// - Normally open ignores sample select and monitors continuously.
// - Stopped oscillator makes a sampling channel monitor continuously.
// - During external wipe pulse, channel two high-level tamper is not detected.
// - Normally closed: pull strength picks strong or weak pull; open ignores it.
// - Internal wipe plus arm clears user RAM and deselects it until disarm.
// - Width bits give external wipe 1, 4, 8 or 16 seconds.
`timescale 1ns/1ps
`default_nettype none
module tdl_top #(
  parameter int P_CYC_PER_SEC = tdl_pkg::SEC_CYCLES
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_tamper_input_one,
  input  wire logic             i_tamper_input_two,
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic [7:0]       i_reg_wdata,
  input  wire logic             i_reg_rd,
  input  wire tdl_pkg::tdl_sys_t i_sys,
  input  wire logic [1:0]       i_wipe_width,
  output logic [7:0]            o_reg_rdata,
  output logic                  o_tamper_irq,
  output logic                  o_ram_wipe,
  output logic                  o_ram_deselect,
  output logic                  o_ext_wipe,
  output logic [1:0]            o_pull_strong
);
  import tdl_pkg::*;

  localparam logic [CNT_W-1:0] SEC_LAST = CNT_W'(P_CYC_PER_SEC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [1:0]       sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [CNT_W-1:0] sec_cnt_reg, sec_cnt_next;
  logic             sec_strobe_reg, sec_strobe_next;
  tdl_cfg_t         cfg_reg [2];
  tdl_cfg_t         cfg_next [2];
  logic [1:0]       flag_reg, flag_next, desel_reg, desel_next;
  logic [1:0]       evt, sampled;
  logic [CNT_W-1:0] ext_cnt_reg, ext_cnt_next;
  logic             ext_busy;
  logic [7:0]       rdata_reg, rdata_next;
  logic             irq_reg, irq_next, wipe_reg, wipe_next;
  logic             desel_out_reg, desel_out_next, ext_out_reg, ext_out_next;
  logic [1:0]       pull_reg, pull_next;

  // Read mux for the three registers; unmapped offsets read zero.
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [1:0] flags,
                                          input tdl_cfg_t c1, input tdl_cfg_t c2);
    logic [7:0] d;
    d = 8'h00;
    if (addr == ADDR_FLAGS) begin
      d[FLAG_ONE_BIT] = flags[0];
      d[FLAG_TWO_BIT] = flags[1];
    end else if (addr == ADDR_CH1) begin
      d = c1;
    end else if (addr == ADDR_CH2) begin
      d = c2;
    end
    return d;
  endfunction

  // Synchronizer stages and the one-second divider.
  always_comb begin
    sync1_next      = {i_tamper_input_two, i_tamper_input_one};
    sync2_next      = sync1_reg;
    sec_strobe_next = (sec_cnt_reg == SEC_LAST);
    sec_cnt_next    = sec_strobe_next ? '0 : sec_cnt_reg + CNT_ONE;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_reg      <= 2'h0;
      sync2_reg      <= 2'h0;
      sec_cnt_reg    <= '0;
      sec_strobe_reg <= 1'b0;
    end else begin
      sync1_reg      <= sync1_next;
      sync2_reg      <= sync2_next;
      sec_cnt_reg    <= sec_cnt_next;
      sec_strobe_reg <= sec_strobe_next;
    end
  end

  // Per-channel detection, flags, configuration writes and RAM deselect.
  assign ext_busy = (ext_cnt_reg != '0);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cfg_next[i] = cfg_reg[i];
      // Sampling only for normally closed with the oscillator running.
      sampled[i]  = ~cfg_reg[i].switch_kind & cfg_reg[i].sample_select
                    & ~i_sys.osc_stopped;
      evt[i] = cfg_reg[i].arm
               & (sync2_reg[i] == cfg_reg[i].trigger_level)
               & (~sampled[i] | sec_strobe_reg)
               & ~flag_reg[i];
      flag_next[i]  = cfg_reg[i].arm & (flag_reg[i] | evt[i]);
      desel_next[i] = cfg_reg[i].arm
                      & (desel_reg[i] | (evt[i] & cfg_reg[i].ram_wipe));
      pull_next[i]  = ~cfg_reg[i].switch_kind & cfg_reg[i].pull_strength;
    end
    // Channel two high-level tamper is masked while the external wipe runs.
    if (ext_busy && cfg_reg[1].trigger_level) begin
      evt[1]       = 1'b0;
      flag_next[1] = cfg_reg[1].arm & flag_reg[1];
      desel_next[1] = cfg_reg[1].arm & desel_reg[1];
    end
    if (i_reg_wr && i_reg_addr == ADDR_CH1) begin
      cfg_next[0] = i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == ADDR_CH2) begin
      cfg_next[1] = i_reg_wdata;
    end
    wipe_next      = |(evt & {cfg_reg[1].ram_wipe, cfg_reg[0].ram_wipe});
    desel_out_next = |desel_next;
    irq_next = |(flag_next & {cfg_reg[1].irq_en, cfg_reg[0].irq_en})
               & (~i_sys.battery_backup | i_sys.alarm_in_backup_enable);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cfg_reg[0]    <= CFG_RESET;
      cfg_reg[1]    <= CFG_RESET;
      flag_reg      <= 2'h0;
      desel_reg     <= 2'h0;
      pull_reg      <= 2'h0;
      wipe_reg      <= 1'b0;
      desel_out_reg <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      cfg_reg[0]    <= cfg_next[0];
      cfg_reg[1]    <= cfg_next[1];
      flag_reg      <= flag_next;
      desel_reg     <= desel_next;
      pull_reg      <= pull_next;
      wipe_reg      <= wipe_next;
      desel_out_reg <= desel_out_next;
      irq_reg       <= irq_next;
    end
  end

  // External wipe pulse timer, loaded on a tamper with external wipe set.
  always_comb begin
    ext_cnt_next = ext_busy ? ext_cnt_reg - CNT_ONE : '0;
    if (!ext_busy && |(evt & {cfg_reg[1].ext_ram_wipe, cfg_reg[0].ext_ram_wipe})) begin
      ext_cnt_next = CNT_W'(tdl_wipe_secs(i_wipe_width) * P_CYC_PER_SEC);
    end
    ext_out_next = (ext_cnt_next != '0);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ext_cnt_reg <= '0;
      ext_out_reg <= 1'b0;
    end else begin
      ext_cnt_reg <= ext_cnt_next;
      ext_out_reg <= ext_out_next;
    end
  end

  // Registered read data, updated on a read strobe.
  always_comb begin
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      rdata_next = reg_read(i_reg_addr, flag_reg, cfg_reg[0], cfg_reg[1]);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops.
  assign o_reg_rdata    = rdata_reg;
  assign o_tamper_irq   = irq_reg;
  assign o_ram_wipe     = wipe_reg;
  assign o_ram_deselect = desel_out_reg;
  assign o_ext_wipe     = ext_out_reg;
  assign o_pull_strong  = pull_reg;

  // Checks on flag, interrupt, wipe and pull strength behaviour.
  AST_FLAG_NEEDS_ARM: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(flag_reg[0]) |-> $past(cfg_reg[0].arm)) else $error("Flag set while disarmed.");
  AST_FLAG_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !cfg_reg[1].arm |=> !flag_reg[1]) else $error("Flag survived disarm.");
  AST_FLAG_STICKY: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    flag_reg[0] && cfg_reg[0].arm |=> flag_reg[0]) else $error("Flag dropped while armed.");
  AST_OPEN_DETECT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cfg_reg[0].arm && cfg_reg[0].switch_kind && sync2_reg[0] == cfg_reg[0].trigger_level
    |=> flag_reg[0]) else $error("Open switch tamper missed.");
  AST_SAMPLE_GATE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    sampled[0] && !sec_strobe_reg && !flag_reg[0] |=> !flag_reg[0])
    else $error("Sampled channel fired off strobe.");
  AST_OSC_FALLBACK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cfg_reg[0].arm && !cfg_reg[0].switch_kind && i_sys.osc_stopped
    && sync2_reg[0] == cfg_reg[0].trigger_level |=> flag_reg[0])
    else $error("No continuous fallback.");
  AST_IRQ_EVENT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    evt[0] && cfg_reg[0].irq_en && !i_sys.battery_backup |=> o_tamper_irq)
    else $error("Interrupt missing on tamper.");
  AST_IRQ_BACKUP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_sys.battery_backup && !i_sys.alarm_in_backup_enable |=> !o_tamper_irq)
    else $error("Interrupt in backup without enable.");
  AST_EXT_MASK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ext_busy && cfg_reg[1].trigger_level && !flag_reg[1] |=> !flag_reg[1])
    else $error("Channel two fired during wipe pulse.");
  AST_RAM_WIPE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    evt[1] && cfg_reg[1].ram_wipe |=> o_ram_wipe && o_ram_deselect)
    else $error("RAM wipe not started.");
  AST_PULL_OPEN: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cfg_reg[0].switch_kind |=> !o_pull_strong[0]) else $error("Pull strength in open mode.");
endmodule
`default_nettype wire

// File: verif/tdl_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module tdl_switch_model (
  input  wire logic [1:0] i_tamper,
  input  wire logic [1:0] i_level,
  output logic      [1:0] o_pin
);
  // A tampered switch takes its pin to the trigger rail.
  // An untouched switch leaves the pin resting on the other rail.
  assign o_pin = ~(i_tamper ^ i_level);
endmodule
`default_nettype wire

// File: verif/tdl_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tdl_top_tb_top;
  import tdl_pkg::*;
  localparam int CYC = 16;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic [1:0]          tamper = 2'h0;
  logic [1:0]          level = 2'h0;
  logic [1:0]          pins;
  logic [7:0]          addr = 8'h00;
  logic [7:0]          wdata = 8'h00;
  logic                wr_s = 1'b0;
  logic                rd_s = 1'b0;
  tdl_sys_t            sys = '0;
  logic [1:0]          width = 2'h0;
  logic [7:0]          rdata;
  logic                irq, wipe, desel, ext;
  logic [1:0]          pull;
  logic [7:0]          cfgs [3] = '{8'h98, 8'h98, 8'hB8};
  logic [7:0]          exps [3] = '{8'h00, 8'h01, 8'h01};
  int                  secs [4] = '{1, 4, 8, 16};
  int                  bad_count, samples_checked, cnt, ext_cnt, ext_base, i, n;

  // Free-running clock and a cycle count since reset release for sample phase.
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cnt <= rst ? 0 : cnt + 1;
  always @(posedge sys_clk) if (ext === 1'b1) ext_cnt <= ext_cnt + 1;

  tdl_switch_model i_sw (.i_tamper(tamper), .i_level(level), .o_pin(pins));
  tdl_top #(.P_CYC_PER_SEC(CYC)) i_dut (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_tamper_input_one(pins[0]),
    .i_tamper_input_two(pins[1]), .i_reg_addr(addr), .i_reg_wr(wr_s),
    .i_reg_wdata(wdata), .i_reg_rd(rd_s), .i_sys(sys), .i_wipe_width(width),
    .o_reg_rdata(rdata), .o_tamper_irq(irq), .o_ram_wipe(wipe),
    .o_ram_deselect(desel), .o_ext_wipe(ext), .o_pull_strong(pull));

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  // Register write and read on the strobe port, one strobe cycle each.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge sys_clk);
    wr_s = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(negedge sys_clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge sys_clk);
    rd_s = 1'b0;
    @(negedge sys_clk);
    chk(nm, {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic stop_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about seven hundred cycles.
  initial begin
    #(8000 * 100);
    bad_count++;
    stop_test();
  end

  // Main sequence.
  initial begin
    cyc(10);
    rst = 1'b0;
    rd(ADDR_FLAGS, 8'h00, "flags_rst");
    rd(ADDR_CH1, CFG_RESET, "cfg1_rst");
    rd(ADDR_CH2, CFG_RESET, "cfg2_rst");
    rd(8'h33, 8'h00, "unmapped");
    wr(ADDR_FLAGS, 8'hFF);
    rd(ADDR_FLAGS, 8'h00, "flags_ro");
    tamper = 2'h3;
    cyc(6);
    rd(ADDR_FLAGS, 8'h00, "disarmed");
    tamper = 2'h0;
    level[0] = 1'b1;
    wr(ADDR_CH1, 8'hF4);
    rd(ADDR_CH1, 8'hF4, "cfg1");
    chk("pull_open", 16'h0, {14'h0, pull});
    chk("irq_idle", 16'h0, {15'h0, irq});
    tamper[0] = 1'b1;
    cyc(5);
    chk("irq_set", 16'h1, {15'h0, irq});
    tamper[0] = 1'b0;
    cyc(5);
    rd(ADDR_FLAGS, 8'h01, "flag1_held");
    sys.battery_backup = 1'b1;
    cyc(2);
    chk("irq_bk", 16'h0, {15'h0, irq});
    sys.alarm_in_backup_enable = 1'b1;
    cyc(2);
    chk("irq_bk_abe", 16'h1, {15'h0, irq});
    sys = '0;
    wr(ADDR_CH1, 8'h74);
    cyc(2);
    rd(ADDR_FLAGS, 8'h00, "flag1_clr");
    chk("irq_clr", 16'h0, {15'h0, irq});
    wr(ADDR_CH2, 8'h86);
    cyc(1);
    chk("pull_closed", 16'h2, {14'h0, pull});
    tamper[1] = 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge sys_clk);
      n += int'(wipe === 1'b1);
    end
    chk("wipe_pulse", 16'h1, n[15:0]);
    chk("desel_on", 16'h1, {15'h0, desel});
    chk("irq_off", 16'h0, {15'h0, irq});
    rd(ADDR_FLAGS, 8'h02, "flag2");
    tamper[1] = 1'b0;
    wr(ADDR_CH2, 8'h06);
    cyc(2);
    chk("desel_off", 16'h0, {15'h0, desel});
    for (i = 0; i < 3; i++) begin
      wr(ADDR_CH1, 8'h18);
      wr(ADDR_CH1, cfgs[i]);
      sys.osc_stopped = (i == 1);
      while (cnt % CYC != 3) @(negedge sys_clk);
      tamper[0] = 1'b1;
      cyc(7);
      tamper[0] = 1'b0;
      cyc(4);
      rd(ADDR_FLAGS, exps[i], "sampled");
    end
    sys = '0;
    wr(ADDR_CH1, 8'h00);
    level[1] = 1'b1;
    for (i = 0; i < 4; i++) begin
      width = i[1:0];
      ext_base = ext_cnt;
      wr(ADDR_CH2, 8'hB1);
      tamper[1] = 1'b1;
      n = 0;
      while (ext !== 1'b1 && n < 10) begin
        cyc(1);
        n++;
      end
      tamper[1] = 1'b0;
      if (i > 0) begin
        wr(ADDR_CH2, 8'h31);
        wr(ADDR_CH2, 8'hB1);
        tamper[1] = 1'b1;
        cyc(3);
        tamper[1] = 1'b0;
        rd(ADDR_FLAGS, 8'h00, "masked");
      end
      n = 0;
      while (ext !== 1'b0 && n < 400) begin
        cyc(1);
        n++;
      end
      chk("ext_len", 16'(secs[i] * CYC), 16'(ext_cnt - ext_base));
      wr(ADDR_CH2, 8'h31);
    end
    stop_test();
  end
endmodule
`default_nettype wire
